// >>> tb/rmosl_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module rmosl_periph_model (
	input wire logic aclk,
	input wire logic aresetn,
	output var logic [rmosl_pkg::NUM_FUNC-1:0] periph_out
);
	// Fresh levels every cycle, so a stale route shows at once
	always @(posedge aclk) begin
		if (!aresetn) begin
			periph_out <= '0;
		end else begin
			periph_out <= (rmosl_pkg::NUM_FUNC)'($urandom & 32'hffff_fffe);
		end
	end
endmodule : rmosl_periph_model
`default_nettype wire

// >>> tb/tb_rmosl_remap.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rmosl_remap;
	// Clock, reset and bus master
	logic aclk, aresetn;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	// Cell upset injection
	logic upset_en;
	logic [2:0] upset_idx;
	logic [15:0] upset_flip;
	// Far side and pins
	logic [rmosl_pkg::NUM_FUNC-1:0] periph_out;
	logic [rmosl_pkg::NUM_PINS-1:0] remappable_pin, pin_drive;
	logic cfg_req;
	// Expected answers, oldest first
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	int fail_count, cmp_count, seed_val;
	logic [9:0] r;

	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	rmosl_remap #(.LARGE_PKG(1'b1)) i_rmosl_remap (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .periph_out(periph_out), .upset_en(upset_en),
		.upset_idx(upset_idx), .upset_flip(upset_flip), .remappable_pin(remappable_pin),
		.pin_drive(pin_drive), .cfg_mismatch_rst_req(cfg_req));

	rmosl_periph_model i_rmosl_periph_model (.aclk(aclk), .aresetn(aresetn),
		.periph_out(periph_out));

	// One comparison, reported on mismatch
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk

	// Verdict and end of run
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	// Watcher: answers against the oldest note
	always @(posedge aclk) begin : watch
		logic [1:0] eb;
		logic [33:0] er;
		if (bvalid === 1'b1 && bready) begin
			eb = bq.pop_front();
			chk(bresp === eb, "write response");
		end
		if (rvalid === 1'b1 && rready) begin
			er = rq.pop_front();
			chk({rresp, rdata} === er, "read data or response");
		end
	end

	// Bus write of one 16-bit register
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s,
		input logic [1:0] e);
		logic ad, wd;
		bq.push_back(e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= {2'h0, s};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ad = 1'b0;
		wd = 1'b0;
		// Hold each channel until its own ready; only the watchdog ends a hang
		do begin
			@(posedge aclk);
			if (awready === 1'b1) ad = 1'b1;
			if (wready === 1'b1) wd = 1'b1;
			awvalid <= !ad;
			wvalid <= !wd;
		end while (!(ad && wd));
		do begin
			@(posedge aclk);
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : wr

	// Bus read, expected value noted first
	task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
		rq.push_back({e, 16'h0000, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask : rd

	// Pin k against the function level sampled one edge before
	task automatic pin_chk(input int k, input logic [4:0] c);
		logic [rmosl_pkg::NUM_FUNC-1:0] p;
		logic v;
		@(posedge aclk);
		p = periph_out;
		v = (c >= 5'h01 && c <= 5'h0c) || (c >= 5'h12 && c <= 5'h16);
		#1;
		chk(pin_drive[k] === v, "pin drive flag");
		chk(remappable_pin[k] === (v ? p[c] : 1'b0), "pin level");
	endtask : pin_chk

	// Full key sequence then the lock write
	task automatic key(input logic [15:0] v, input logic [1:0] s);
		wr(rmosl_pkg::OFF_OSC, 16'h0046, 2'h1, rmosl_pkg::RESP_OKAY);
		wr(rmosl_pkg::OFF_OSC, 16'h0057, 2'h1, rmosl_pkg::RESP_OKAY);
		wr(rmosl_pkg::OFF_OSC, v, s, rmosl_pkg::RESP_OKAY);
	endtask : key

	// Main sequence
	initial begin
		seed_val = $urandom(75666);
		{aresetn, awvalid, wvalid, bready, arvalid, rready, upset_en} = '0;
		{awaddr, araddr, wdata, wstrb, upset_idx, upset_flip} = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(rmosl_pkg::OFF_OSC, 16'h0000, rmosl_pkg::RESP_OKAY);
		for (int i = 0; i < 5; i++) rd(8'h10 + 8'(4 * i), 16'h0000, 2'h0);
		rd(8'h30, 16'h0000, rmosl_pkg::RESP_SLVERR);
		wr(8'h30, 16'hffff, 2'h3, rmosl_pkg::RESP_SLVERR);
		// Every output pair: fields, dead bits, random routes
		for (int i = 0; i < 4; i++) begin
			wr(8'h10 + 8'(4 * i), 16'hffff, 2'h3, 2'h0);
			rd(8'h10 + 8'(4 * i), 16'h1f1f, 2'h0);
			r = 10'($urandom);
			wr(8'h10 + 8'(4 * i), {3'h7, r[9:5], 3'h7, r[4:0]}, 2'h3, 2'h0);
			pin_chk(2 * i, r[4:0]);
			pin_chk(2 * i + 1, r[9:5]);
		end
		// Upper lane only: the last pair keeps its random low field
		wr(8'h1c, 16'h0000, 2'h2, 2'h0);
		rd(8'h1c, {11'h000, r[4:0]}, 2'h0);
		// Every code, both fields of the first pair
		for (int c = 0; c < 32; c++) begin
			wr(rmosl_pkg::OFF_MAP0, {3'h0, 5'(31 - c), 3'h0, 5'(c)}, 2'h3, 2'h0);
			pin_chk(0, 5'(c));
			pin_chk(1, 5'(31 - c));
		end
		wr(8'h14, 16'h0102, 2'h3, 2'h0);
		chk(cfg_req === 1'b0, "no request after legal writes");
		// Lock, with armed state visible in status
		wr(rmosl_pkg::OFF_OSC, 16'h0046, 2'h1, 2'h0);
		wr(rmosl_pkg::OFF_OSC, 16'h0057, 2'h1, 2'h0);
		rd(rmosl_pkg::OFF_STATUS, 16'h0004, 2'h0);
		wr(rmosl_pkg::OFF_OSC, 16'h0040, 2'h1, 2'h0);
		rd(rmosl_pkg::OFF_OSC, 16'h0040, 2'h0);
		wr(8'h14, 16'h1f1f, 2'h3, rmosl_pkg::RESP_OKAY);
		rd(8'h14, 16'h0102, 2'h0);
		// Broken sequence leaves the lock alone
		wr(rmosl_pkg::OFF_OSC, 16'h0046, 2'h1, 2'h0);
		wr(rmosl_pkg::OFF_OSC, 16'h0000, 2'h1, 2'h0);
		wr(rmosl_pkg::OFF_OSC, 16'h0057, 2'h1, 2'h0);
		wr(rmosl_pkg::OFF_OSC, 16'h0000, 2'h1, 2'h0);
		rd(rmosl_pkg::OFF_OSC, 16'h0040, 2'h0);
		key(16'h0000, 2'h2);
		rd(rmosl_pkg::OFF_OSC, 16'h0040, 2'h0);
		wr(8'h14, 16'h0303, 2'h3, 2'h0);
		rd(8'h14, 16'h0102, 2'h0);
		// Unlock, then several updates on one unlock
		key(16'h0000, 2'h1);
		rd(rmosl_pkg::OFF_OSC, 16'h0000, 2'h0);
		wr(8'h14, 16'h0a0b, 2'h3, 2'h0);
		wr(8'h18, 16'h1213, 2'h3, 2'h0);
		rd(8'h14, 16'h0a0b, 2'h0);
		rd(8'h18, 16'h1213, 2'h0);
		wr(rmosl_pkg::OFF_STATUS, 16'hffff, 2'h3, 2'h0);
		chk(cfg_req === 1'b0, "no request after legal writes");
		// Disturb a live cell behind the shadow
		@(posedge aclk);
		upset_idx <= 3'h1;
		upset_flip <= 16'h0100;
		upset_en <= 1'b1;
		@(posedge aclk);
		upset_en <= 1'b0;
		repeat (3) @(posedge aclk);
		#1;
		chk(cfg_req === 1'b1, "mismatch request raised");
		rd(rmosl_pkg::OFF_STATUS, 16'h0001, 2'h0);
		// Device reset clears the request and every selector
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h14, 16'h0000, 2'h0);
		chk(cfg_req === 1'b0, "request cleared by reset");
		repeat (2) @(posedge aclk);
		results();
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		results();
	end
endmodule : tb_rmosl_remap
`default_nettype wire

// >>> verilog/rmosl_key_lock.sv
`timescale 1ns/1ps
`default_nettype none
module rmosl_key_lock (
	input wire logic aclk,
	input wire logic aresetn,
	input wire rmosl_pkg::rmosl_wr_t wr,
	output logic lock,
	output rmosl_pkg::rmosl_key_t key_state
);
	rmosl_pkg::rmosl_key_t state_r; // Key progress
	rmosl_pkg::rmosl_key_t state_nxt;
	logic lock_r; // Mapping write lock
	logic osc_wr; // Any write to the oscillator control word
	logic [7:0] lo_byte; // Written low byte

	assign osc_wr = wr.en && (wr.addr == rmosl_pkg::OFF_OSC);
	assign lo_byte = wr.data[7:0];

	// Next key state
	always_comb begin
		state_nxt = state_r;
		if (osc_wr) begin
			case (state_r)
				rmosl_pkg::KEY_IDLE: begin
					// First key byte
					state_nxt = (wr.strb[0] && lo_byte == rmosl_pkg::KEY_BYTE1) ?
						rmosl_pkg::KEY_FIRST : rmosl_pkg::KEY_IDLE;
				end
				rmosl_pkg::KEY_FIRST: begin
					// Second key byte, else restart or abandon
					if (wr.strb[0] && lo_byte == rmosl_pkg::KEY_BYTE2) begin
						state_nxt = rmosl_pkg::KEY_ARMED;
					end else if (wr.strb[0] && lo_byte == rmosl_pkg::KEY_BYTE1) begin
						state_nxt = rmosl_pkg::KEY_FIRST;
					end else begin
						state_nxt = rmosl_pkg::KEY_IDLE;
					end
				end
				rmosl_pkg::KEY_ARMED: begin
					// One write consumes the arming
					state_nxt = rmosl_pkg::KEY_IDLE;
				end
				default: begin
					state_nxt = rmosl_pkg::KEY_IDLE;
				end
			endcase
		end
	end

	// Key state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= rmosl_pkg::KEY_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Lock bit changes only on the armed single write; never relocks alone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_r <= rmosl_pkg::LOCK_RST;
		end else if (osc_wr && state_r == rmosl_pkg::KEY_ARMED && wr.strb[0]) begin
			lock_r <= wr.data[rmosl_pkg::LOCK_BIT];
		end
	end

	assign lock = lock_r;
	assign key_state = state_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Stray byte between keys drops the sequence
	a_key_abandon: assert property ((state_r == rmosl_pkg::KEY_FIRST) && osc_wr && (!wr.strb[0]
		|| (lo_byte != rmosl_pkg::KEY_BYTE2 && lo_byte != rmosl_pkg::KEY_BYTE1))
		|=> state_r == rmosl_pkg::KEY_IDLE) else $error("key not abandoned");
	// Lock moves only one cycle after an armed write
	a_lock_armed_only: assert property ($changed(lock_r) |-> $past(state_r) ==
		rmosl_pkg::KEY_ARMED && $past(osc_wr)) else $error("lock changed unarmed");
	c_lock_cleared: cover property ($fell(lock_r));
endmodule : rmosl_key_lock
`default_nettype wire

// >>> verilog/rmosl_pkg.sv
`default_nettype none
package rmosl_pkg;
	// Register byte addresses
	localparam logic [7:0] OFF_OSC = 8'h00;
	localparam logic [7:0] OFF_MAP0 = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam int ADDR_W = 8;
	// Mapping register array: 0..3 output pairs, 4 input pair
	localparam int NUM_MAP = 5;
	localparam int NUM_OUT_MAP = 4;
	localparam int NUM_PINS = 8;
	localparam int SEL_W = 5;
	localparam int HI_SEL_LSB = 8;
	localparam int LO_SEL_LSB = 0;
	localparam logic [15:0] FIELD_MASK = 16'h1f1f;
	// Output pairs present only on the larger package
	localparam int LARGE_IDX_LO = 2;
	localparam int LARGE_IDX_HI = 3;
	// Lock bit and key bytes
	localparam int LOCK_BIT = 6;
	localparam logic [7:0] KEY_BYTE1 = 8'h46;
	localparam logic [7:0] KEY_BYTE2 = 8'h57;
	// Reset values
	localparam logic LOCK_RST = 1'b0;
	localparam logic [15:0] MAP_RST = 16'h0000;
	// Output function codes
	localparam logic [4:0] FUNC_NULL = 5'h00;
	localparam logic [4:0] FUNC_GAP_LO = 5'h0d;
	localparam logic [4:0] FUNC_GAP_HI = 5'h11;
	localparam logic [4:0] FUNC_LAST = 5'h16;
	localparam int NUM_FUNC = 23;
	// Status register fields
	localparam int ST_MISMATCH_BIT = 0;
	localparam int ST_KEY_LSB = 1;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Key sequence states
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_FIRST = 2'b01,
		KEY_ARMED = 2'b10
	} rmosl_key_t;

	// One committed register write
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [15:0] data;
		logic [1:0] strb;
	} rmosl_wr_t;

	// All mapping registers side by side
	typedef logic [NUM_MAP-1:0][15:0] rmosl_map_t;
endpackage : rmosl_pkg
`default_nettype wire

// >>> verilog/rmosl_remap.sv
`timescale 1ns/1ps
`default_nettype none
module rmosl_remap #(
	parameter bit LARGE_PKG = 1'b1 // Larger package variant present
) (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral outputs, index is the function code
	input wire logic [rmosl_pkg::NUM_FUNC-1:0] periph_out,
	// Cell upset injection into a live mapping register
	input wire logic upset_en,
	input wire logic [2:0] upset_idx,
	input wire logic [15:0] upset_flip,
	// Remappable pin outputs: pins 8,9,10,11,20,21,22,23
	output logic [rmosl_pkg::NUM_PINS-1:0] remappable_pin,
	output logic [rmosl_pkg::NUM_PINS-1:0] pin_drive,
	// Configuration mismatch reset request
	output logic cfg_mismatch_rst_req
);
	// Write channel holding
	logic aw_have_r; // Address taken, waiting for data
	logic [7:0] aw_addr_r;
	logic w_have_r; // Data taken, waiting for address
	logic [15:0] w_data_r;
	logic [1:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	// Read channel
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	// Register state
	rmosl_pkg::rmosl_map_t map_r; // Live mapping registers
	rmosl_pkg::rmosl_map_t map_nxt;
	rmosl_pkg::rmosl_map_t wr_val; // Merged write values
	logic [rmosl_pkg::NUM_MAP-1:0] commit; // Permitted write per register
	rmosl_pkg::rmosl_wr_t wr; // Write being performed this cycle
	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic map_hit; // Write lands on a mapping register
	logic lock; // Mapping write lock
	rmosl_pkg::rmosl_key_t key_state;
	logic mismatch;
	logic [rmosl_pkg::NUM_PINS-1:0] pin_out_r;
	logic [rmosl_pkg::NUM_PINS-1:0] pin_drive_r;
	logic [rmosl_pkg::NUM_PINS-1:0][4:0] sel; // Selector per pin

	// Implemented bits of mapping register idx
	function automatic logic [15:0] reg_mask(input int idx);
		if (idx >= rmosl_pkg::NUM_MAP) begin
			reg_mask = 16'h0000;
		end else if (!LARGE_PKG && (idx == rmosl_pkg::LARGE_IDX_LO ||
			idx == rmosl_pkg::LARGE_IDX_HI)) begin
			reg_mask = 16'h0000;
		end else begin
			reg_mask = rmosl_pkg::FIELD_MASK;
		end
	endfunction : reg_mask

	// Mapping register index of a byte address, NUM_MAP when none
	function automatic int map_index(input logic [7:0] addr);
		map_index = rmosl_pkg::NUM_MAP;
		for (int i = 0; i < rmosl_pkg::NUM_MAP; i++) begin
			if (addr == rmosl_pkg::OFF_MAP0 + 8'(4 * i)) begin
				map_index = i;
			end
		end
	endfunction : map_index

	// Byte-lane merge under the implemented-bit mask
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data,
		input logic [1:0] strb, input logic [15:0] mask);
		logic [15:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}};
		merge = ((old & ~lanes) | (data & lanes)) & mask;
	endfunction : merge

	// Output function of one selector; {drive, level}
	function automatic logic [1:0] route(input logic [4:0] code,
		input logic [rmosl_pkg::NUM_FUNC-1:0] fn);
		if (code == rmosl_pkg::FUNC_NULL || code > rmosl_pkg::FUNC_LAST ||
			(code >= rmosl_pkg::FUNC_GAP_LO && code <= rmosl_pkg::FUNC_GAP_HI)) begin
			route = 2'b00;
		end else begin
			route = {1'b1, fn[code]};
		end
	endfunction : route

	// Handshakes
	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready = !w_have_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign ar_fire = s_axi_arvalid && s_axi_arready;

	// Write performed once address and data are both present
	always_comb begin
		wr.en = (aw_have_r || aw_fire) && (w_have_r || w_fire) && !bvalid_r;
		wr.addr = aw_have_r ? aw_addr_r : s_axi_awaddr;
		wr.data = w_have_r ? w_data_r : s_axi_wdata[15:0];
		wr.strb = w_have_r ? w_strb_r : s_axi_wstrb[1:0];
	end

	assign map_hit = wr.en && (map_index(wr.addr) < rmosl_pkg::NUM_MAP);

	// Address and data holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_have_r <= 1'b0;
			w_data_r <= 16'h0000;
			w_strb_r <= 2'b00;
		end else if (wr.en) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
		end else begin
			if (aw_fire) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata[15:0];
				w_strb_r <= s_axi_wstrb[1:0];
			end
		end
	end

	// Write response; locked map writes still answer OKAY
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= rmosl_pkg::RESP_OKAY;
		end else if (wr.en) begin
			bvalid_r <= 1'b1;
			if (map_hit || wr.addr == rmosl_pkg::OFF_OSC || wr.addr == rmosl_pkg::OFF_STATUS) begin
				bresp_r <= rmosl_pkg::RESP_OKAY;
			end else begin
				bresp_r <= rmosl_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Next live values: permitted writes, then any cell upset
	always_comb begin
		for (int i = 0; i < rmosl_pkg::NUM_MAP; i++) begin
			commit[i] = map_hit && !lock && (map_index(wr.addr) == i);
			wr_val[i] = merge(map_r[i], wr.data, wr.strb, reg_mask(i));
			map_nxt[i] = commit[i] ? wr_val[i] : map_r[i];
			if (upset_en && int'(upset_idx) == i) begin
				map_nxt[i] = map_nxt[i] ^ (upset_flip & reg_mask(i));
			end
		end
	end

	// Live mapping registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < rmosl_pkg::NUM_MAP; i++) begin
				map_r[i] <= rmosl_pkg::MAP_RST;
			end
		end else begin
			map_r <= map_nxt;
		end
	end

	// Read data decode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= rmosl_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_r <= 1'b1;
			rresp_r <= rmosl_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			if (s_axi_araddr == rmosl_pkg::OFF_OSC) begin
				rdata_r[rmosl_pkg::LOCK_BIT] <= lock;
			end else if (s_axi_araddr == rmosl_pkg::OFF_STATUS) begin
				rdata_r[rmosl_pkg::ST_MISMATCH_BIT] <= cfg_mismatch_rst_req;
				rdata_r[rmosl_pkg::ST_KEY_LSB +: 2] <= key_state;
			end else if (map_index(s_axi_araddr) < rmosl_pkg::NUM_MAP) begin
				rdata_r[15:0] <= map_r[map_index(s_axi_araddr)];
			end else begin
				rresp_r <= rmosl_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// Selector fields: even pin low field, odd pin high field
	always_comb begin
		for (int k = 0; k < rmosl_pkg::NUM_PINS; k++) begin
			sel[k] = (k % 2 == 1) ? map_r[k / 2][rmosl_pkg::HI_SEL_LSB +: rmosl_pkg::SEL_W] :
				map_r[k / 2][rmosl_pkg::LO_SEL_LSB +: rmosl_pkg::SEL_W];
		end
	end

	// Registered pin drivers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out_r <= '0;
			pin_drive_r <= '0;
		end else begin
			for (int k = 0; k < rmosl_pkg::NUM_PINS; k++) begin
				// Drive flag and level from one lookup
				{pin_drive_r[k], pin_out_r[k]} <= route(sel[k], periph_out);
			end
		end
	end

	assign remappable_pin = pin_out_r;
	assign pin_drive = pin_drive_r;

	rmosl_key_lock u_key_lock (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr(wr),
		.lock(lock),
		.key_state(key_state)
	);

	rmosl_shadow_mon u_shadow_mon (
		.aclk(aclk),
		.aresetn(aresetn),
		.live(map_r),
		.wr_val(wr_val),
		.commit(commit),
		.mismatch(mismatch),
		.rst_req(cfg_mismatch_rst_req)
	);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Locked map write leaves every register as it was
	a_locked_write_hold: assert property (map_hit && lock && !upset_en |=> $stable(map_r))
		else $error("locked write changed map");
	// Lock read back at bit six
	a_lock_readback: assert property (ar_fire && s_axi_araddr == rmosl_pkg::OFF_OSC |=>
		rdata_r[rmosl_pkg::LOCK_BIT] == $past(lock) && rvalid_r) else $error("lock bit bad");
	// Lock moves only after an oscillator word write
	a_lock_persists: assert property ($changed(lock) |-> $past(wr.en) &&
		$past(wr.addr) == rmosl_pkg::OFF_OSC) else $error("lock changed by itself");
	// Legitimate writes never raise the request
	a_legal_no_mismatch: assert property (!mismatch && !upset_en |=> !mismatch)
		else $error("legal write mismatched");
	// Upset of an implemented bit requests reset two cycles on
	a_upset_request: assert property (upset_en && int'(upset_idx) < rmosl_pkg::NUM_MAP &&
		(upset_flip & reg_mask(int'(upset_idx))) != 16'h0000 |-> ##2 cfg_mismatch_rst_req)
		else $error("upset missed");
	// Unimplemented bits of mapping registers 0, 2 and 3 always zero
	a_unimpl_zero: assert property ((map_r[0] & ~reg_mask(0)) == 16'h0000 &&
		(map_r[2] & ~reg_mask(2)) == 16'h0000 && (map_r[3] & ~reg_mask(3)) == 16'h0000)
		else $error("unimplemented bit set");
	// Null and gap codes leave the pin undriven
	a_pin_null: assert property ((sel[0] == rmosl_pkg::FUNC_NULL || (sel[0] >=
		rmosl_pkg::FUNC_GAP_LO && sel[0] <= rmosl_pkg::FUNC_GAP_HI)) |=> !pin_drive_r[0])
		else $error("null code drove pin");
	// Selected function reaches the pin one cycle later
	a_pin_route: assert property (sel[1] == 5'h03 |=> pin_drive_r[1] &&
		pin_out_r[1] == $past(periph_out[3])) else $error("route wrong");
	c_map_written: cover property (commit[0] ##1 pin_drive_r[0]);
	c_locked_write: cover property (map_hit && lock);
	c_unmapped_read: cover property (rvalid_r && rresp_r == rmosl_pkg::RESP_SLVERR);
endmodule : rmosl_remap
`default_nettype wire

// >>> verilog/rmosl_shadow_mon.sv
`timescale 1ns/1ps
`default_nettype none
module rmosl_shadow_mon (
	input wire logic aclk,
	input wire logic aresetn,
	input wire rmosl_pkg::rmosl_map_t live,
	input wire rmosl_pkg::rmosl_map_t wr_val,
	input wire logic [rmosl_pkg::NUM_MAP-1:0] commit,
	output logic mismatch,
	output logic rst_req
);
	rmosl_pkg::rmosl_map_t shadow_r; // Copies of the mapping registers
	logic rst_req_r; // Sticky reset request

	// Shadow follows each permitted write on the same edge as the live copy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < rmosl_pkg::NUM_MAP; i++) begin
				shadow_r[i] <= rmosl_pkg::MAP_RST;
			end
		end else begin
			for (int i = 0; i < rmosl_pkg::NUM_MAP; i++) begin
				if (commit[i]) begin
					shadow_r[i] <= wr_val[i];
				end
			end
		end
	end

	// Continuous compare of all registers
	assign mismatch = (live != shadow_r);

	// Request held until device reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_req_r <= 1'b0;
		end else if (mismatch) begin
			rst_req_r <= 1'b1;
		end
	end

	assign rst_req = rst_req_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Any disagreement raises the request next cycle and it stays
	a_mismatch_raise: assert property (mismatch |=> rst_req_r [*3])
		else $error("mismatch not requested");
	c_mismatch_seen: cover property ($rose(rst_req_r));
endmodule : rmosl_shadow_mon
`default_nettype wire
